// File: core/cause_flag_reg.sv
// holds the reset-cause flag register: hardware-set flags that software
// may also write; assumes write enable and lane mask from the bus slave
`timescale 1ns/10ps

module cause_flag_reg
    import reset_cause_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // hardware set pulses, one per bit
    input wire logic [DATA_W-1:0] hwSet,
    // software write
    input wire logic wrEn,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic [DATA_W-1:0] wrLanes,
    // register contents
    output logic [DATA_W-1:0] value_r
);

    logic [DATA_W-1:0] value_nxt;

    always_comb begin
        value_nxt = value_r;
        if (wrEn) begin
            value_nxt = (value_r & ~wrLanes) | (wrData & wrLanes);
        end
        // a set in the same cycle as a software write still lands
        value_nxt = (value_nxt | (hwSet & CAUSE_HWSET_MASK)) & CAUSE_IMPL_MASK;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            value_r <= CAUSE_RESET_VAL;
        end else begin
            value_r <= value_nxt;
        end
    end

endmodule : cause_flag_reg

// File: core/irq_status_unit.sv
// holds the sticky interrupt status (write one to clear), its mask and the
// level interrupt output; assumes one-cycle event pulses from the event inputs
`timescale 1ns/10ps

module irq_status_unit
    import reset_cause_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // events
    input wire logic [DATA_W-1:0] hwSet,
    // software access
    input wire logic statusWrEn,
    input wire logic maskWrEn,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic [DATA_W-1:0] wrLanes,
    // state
    output logic [DATA_W-1:0] status_r,
    output logic [DATA_W-1:0] mask_r,
    output logic irq_r
);

    logic [DATA_W-1:0] status_nxt;
    logic [DATA_W-1:0] mask_nxt;

    always_comb begin
        status_nxt = status_r;
        if (statusWrEn) begin
            status_nxt = status_r & ~(wrData & wrLanes);
        end
        // set wins over a clear in the same cycle
        status_nxt = (status_nxt | hwSet) & CAUSE_HWSET_MASK;
        mask_nxt = mask_r;
        if (maskWrEn) begin
            mask_nxt = ((mask_r & ~wrLanes) | (wrData & wrLanes)) & CAUSE_HWSET_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            status_r <= IRQ_RESET_VAL;
            mask_r <= IRQ_RESET_VAL;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            // computed from next values so the line tracks status without lag
            irq_r <= |(status_nxt & mask_nxt);
        end
    end

endmodule : irq_status_unit

// File: core/reset_cause_pkg.sv
// holds the register map, field positions, reset values and shared types
// of the reset-cause status block; assumes a 32-bit AXI4-Lite register bus
package reset_cause_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    localparam logic [ADDR_W-1:0] CAUSE_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 8'h08;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // reset-cause register fields
    // ------------------------------------------------------------
    localparam int POWER_ON_BIT = 0;
    localparam int BROWNOUT_BIT = 1;
    localparam int IDLE_WAKE_BIT = 2;
    localparam int SLEEP_WAKE_BIT = 3;
    localparam int WATCHDOG_BIT = 4;
    localparam int SOFTWARE_RESET_BIT = 6;
    localparam int EXTERNAL_PIN_BIT = 7;
    localparam int REGULATOR_KEEP_ON_BIT = 8;
    localparam int CONFIG_MISMATCH_BIT = 9;
    localparam int HIGH_VOLTAGE_BIT = 29;

    // implemented bits: 29, 9..6, 4..0
    localparam logic [DATA_W-1:0] CAUSE_IMPL_MASK = 32'h2000_03DF;
    // bits that hardware may set (all flags, not the regulator control)
    localparam logic [DATA_W-1:0] CAUSE_HWSET_MASK = 32'h2000_02DF;
    // power-on and brown-out flags come up set
    localparam logic [DATA_W-1:0] CAUSE_RESET_VAL = 32'h0000_0003;

    localparam logic [DATA_W-1:0] IRQ_RESET_VAL = 32'h0000_0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic powerOn;
        logic brownout;
        logic highVoltage;
        logic configMismatch;
        logic externalPin;
        logic softwareReset;
        logic watchdogTimeout;
        logic wakeFromSleep;
        logic wakeFromIdle;
    } cause_events_t;

    typedef enum logic [0:0] {WR_COLLECT, WR_RESP} wr_state_t;
    typedef enum logic [0:0] {RD_IDLE, RD_DATA} rd_state_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] laneMask(input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < STRB_W; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : laneMask

    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        return (addr == CAUSE_OFFSET) || (addr == IRQ_STATUS_OFFSET) || (addr == IRQ_MASK_OFFSET);
    endfunction : isMapped

    function automatic logic [DATA_W-1:0] eventVector(input cause_events_t e);
        logic [DATA_W-1:0] v;
        v = '0;
        v[POWER_ON_BIT] = e.powerOn;
        v[BROWNOUT_BIT] = e.brownout;
        v[IDLE_WAKE_BIT] = e.wakeFromIdle;
        v[SLEEP_WAKE_BIT] = e.wakeFromSleep;
        v[WATCHDOG_BIT] = e.watchdogTimeout;
        v[SOFTWARE_RESET_BIT] = e.softwareReset;
        v[EXTERNAL_PIN_BIT] = e.externalPin;
        v[CONFIG_MISMATCH_BIT] = e.configMismatch;
        v[HIGH_VOLTAGE_BIT] = e.highVoltage;
        return v;
    endfunction : eventVector

endpackage : reset_cause_pkg

// File: core/reset_cause_status.sv
// top of the reset-cause and wake-cause status block with its AXI4-Lite slave
// assumes event inputs are one-cycle pulses synchronous to sys_clk
//
// What this block does
// - high-voltage reset sets bit 29, else zero
// - configuration mismatch reset sets bit 9
// - bit 8 keeps regulator on in Sleep
// - master-clear pin reset sets bit 7
// - software reset sets bit 6, else zero
// - watchdog time-out sets bit 4
// - wake from Sleep sets bit 3
// - wake from Idle sets bit 2
// - brown-out sets bit 1, one after power-on
// - power-on sets bit 0, one after power-on
// - power-on, brown-out flags stay until software clears
// - unimplemented bits read zero, ignore writes
// - flags writable; reset all zero except bits 1,0
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps

module reset_cause_status
    import reset_cause_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // hardware cause events
    input wire cause_events_t hwEvents,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // block outputs
    output logic regulatorSleepKeepOn,
    output logic irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    wr_state_t wrState_r;
    rd_state_t rdState_r;

    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic awHeld_r;
    logic wHeld_r;
    logic [ADDR_W-1:0] awAddr_r;
    logic [DATA_W-1:0] wData_r;
    logic [STRB_W-1:0] wStrb_r;

    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [DATA_W-1:0] rdata_r;

    logic awTaken;
    logic wTaken;
    logic haveAw;
    logic haveW;
    logic wrGo;
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] wrLanes;
    logic causeWrEn;
    logic statusWrEn;
    logic maskWrEn;

    logic [DATA_W-1:0] eventBits;
    logic [DATA_W-1:0] causeValue;
    logic [DATA_W-1:0] irqStatus;
    logic [DATA_W-1:0] irqMask;
    logic irqLine;
    logic [DATA_W-1:0] readWord;

    // ------------------------------------------------------------
    // event collection
    // ------------------------------------------------------------
    // each documented cause lands on its own flag position
    assign eventBits = eventVector(hwEvents);

    // ------------------------------------------------------------
    // write path decode
    // ------------------------------------------------------------
    // address and data may arrive in either order or together; the held
    // copy is used when one came earlier than the other
    assign awTaken = awvalid && awready_r;
    assign wTaken = wvalid && wready_r;
    assign haveAw = awHeld_r || awTaken;
    assign haveW = wHeld_r || wTaken;
    assign wrGo = (wrState_r == WR_COLLECT) && haveAw && haveW;
    assign wrAddr = awHeld_r ? awAddr_r : awaddr;
    assign wrData = wHeld_r ? wData_r : wdata;
    assign wrLanes = laneMask(wHeld_r ? wStrb_r : wstrb);

    // ------------------------------------------------------------
    // write target decode
    // ------------------------------------------------------------
    // an unmapped address selects no register; it only gets an error response
    always_comb begin
        causeWrEn = 1'b0;
        statusWrEn = 1'b0;
        maskWrEn = 1'b0;
        if (wrGo) begin
            case (wrAddr)
                CAUSE_OFFSET: begin
                    causeWrEn = 1'b1;
                end
                IRQ_STATUS_OFFSET: begin
                    statusWrEn = 1'b1;
                end
                IRQ_MASK_OFFSET: begin
                    maskWrEn = 1'b1;
                end
                default: begin
                    causeWrEn = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // write channel handshakes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wrState_r <= WR_COLLECT;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
        end else begin
            case (wrState_r)
                WR_COLLECT: begin
                    if (wrGo) begin
                        wrState_r <= WR_RESP;
                        awready_r <= 1'b0;
                        wready_r <= 1'b0;
                        awHeld_r <= 1'b0;
                        wHeld_r <= 1'b0;
                    end else begin
                        awHeld_r <= haveAw;
                        wHeld_r <= haveW;
                        awready_r <= !haveAw;
                        wready_r <= !haveW;
                    end
                end
                WR_RESP: begin
                    if (bready) begin
                        wrState_r <= WR_COLLECT;
                        awready_r <= 1'b1;
                        wready_r <= 1'b1;
                    end
                end
                default: begin
                    wrState_r <= WR_COLLECT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // write response
    // ------------------------------------------------------------
    // the response stands until the master takes it, whatever it carries
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (wrGo) begin
                bvalid_r <= 1'b1;
                bresp_r <= isMapped(wrAddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // write payload capture
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            awAddr_r <= '0;
            wData_r <= '0;
            wStrb_r <= '0;
        end else begin
            if (awTaken) begin
                awAddr_r <= awaddr;
            end
            if (wTaken) begin
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end
        end
    end

    // ------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------
    // irq status and mask already hold bit 8 and unused bits at zero
    always_comb begin
        readWord = '0;
        case (araddr)
            CAUSE_OFFSET: begin
                readWord = causeValue & CAUSE_IMPL_MASK;
            end
            IRQ_STATUS_OFFSET: begin
                readWord = irqStatus;
            end
            IRQ_MASK_OFFSET: begin
                readWord = irqMask;
            end
            default: begin
                readWord = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    // a read in the same cycle as a write returns the value before it
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdState_r <= RD_IDLE;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else begin
            case (rdState_r)
                RD_IDLE: begin
                    if (arvalid && arready_r) begin
                        rdState_r <= RD_DATA;
                        arready_r <= 1'b0;
                        rvalid_r <= 1'b1;
                        rresp_r <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
                        rdata_r <= readWord;
                    end else begin
                        arready_r <= 1'b1;
                    end
                end
                RD_DATA: begin
                    if (rready) begin
                        rdState_r <= RD_IDLE;
                        rvalid_r <= 1'b0;
                        arready_r <= 1'b1;
                    end
                end
                default: begin
                    rdState_r <= RD_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // register instances
    // ------------------------------------------------------------
    cause_flag_reg causeReg (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .hwSet(eventBits),
        .wrEn(causeWrEn),
        .wrData(wrData),
        .wrLanes(wrLanes),
        .value_r(causeValue)
    );

    irq_status_unit irqUnit (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .hwSet(eventBits),
        .statusWrEn(statusWrEn),
        .maskWrEn(maskWrEn),
        .wrData(wrData),
        .wrLanes(wrLanes),
        .status_r(irqStatus),
        .mask_r(irqMask),
        .irq_r(irqLine)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign regulatorSleepKeepOn = causeValue[REGULATOR_KEEP_ON_BIT];
    assign irq = irqLine;

endmodule : reset_cause_status

// File: test/reset_cause_status_monitor.sv
// assertions on the bus and output pins of the reset-cause block
// assumes it is bound to reset_cause_status, one clock domain
`timescale 1ns/10ps

module reset_cause_status_monitor
    import reset_cause_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // write side
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [STRB_W-1:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    // read side
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // block outputs
    input wire logic regulatorSleepKeepOn,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    logic wrTake;
    logic rdBad;
    assign wrTake = awvalid && awready && wvalid && wready;
    assign rdBad = arvalid && arready && !(araddr inside {CAUSE_OFFSET, IRQ_STATUS_OFFSET, IRQ_MASK_OFFSET});

    a_write_answer: assert property (wrTake |=> bvalid) else $error("no write response");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
    a_ready_block: assert property (bvalid |-> !awready && !wready) else $error("ready during response");
    a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("no read data");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped");
    a_unmapped_read: assert property (rdBad |=> rresp == RESP_SLVERR && rdata == '0) else $error("bad unmapped read");
    a_unimpl_zero: assert property (rvalid |-> (rdata & ~CAUSE_IMPL_MASK) == '0)
        else $error("unimplemented bit set");
    a_keep_on_write: assert property (wrTake && awaddr == CAUSE_OFFSET && wstrb[1] |=>
        regulatorSleepKeepOn == $past(wdata[REGULATOR_KEEP_ON_BIT])) else $error("keep-on not written");
    a_keep_on_steady: assert property (!$rose(bvalid) |-> $stable(regulatorSleepKeepOn))
        else $error("keep-on moved alone");
    a_reset_clean: assert property ($rose(rst_b) |-> !irq && !regulatorSleepKeepOn && !bvalid && !rvalid)
        else $error("outputs not clear after reset");
endmodule : reset_cause_status_monitor

bind reset_cause_status reset_cause_status_monitor mon (.sys_clk(sys_clk), .rst_b(rst_b),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .regulatorSleepKeepOn(regulatorSleepKeepOn), .irq(irq));

// File: test/reset_cause_status_tb.sv
// self-checking bench for the reset-cause status block
// assumes the block alone, driven over AXI4-Lite and its event pins
`timescale 1ns/10ps

module reset_cause_status_tb
    import reset_cause_pkg::*;
;
    logic sys_clk = 1'h0;
    logic rst_b = 1'h0;
    cause_events_t hwEvents = '0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [DATA_W-1:0] wdata = '0;
    logic [STRB_W-1:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, regulatorSleepKeepOn, irq;
    logic [1:0] bresp, rresp, resp;
    logic [DATA_W-1:0] rdata, rd;
    int numErrors = 0, nTests = 0;

    always #4 sys_clk = ~sys_clk;

    reset_cause_status dut (.sys_clk(sys_clk), .rst_b(rst_b), .hwEvents(hwEvents),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .regulatorSleepKeepOn(regulatorSleepKeepOn), .irq(irq));

    // ----------------------------------------------------------------
    // bus and check helpers
    // ----------------------------------------------------------------
    task automatic wrapUp();
        $display("comparisons %0d, mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrapUp

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic hang(input string what);
        numErrors++;
        $display("wrong value at %0t: %s never answered", $time, what);
        wrapUp();
    endtask : hang

    // entered just after a rising edge; readies are sampled before the edge's updates land
    task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s);
        int n;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        if (n == 64) hang("write");
        bready <= 1'h0;
        resp = bresp;
        // idle edge: a following call must not raise bready in this same step
        @(posedge sys_clk);
    endtask : axiWrite

    task automatic axiRead(input logic [ADDR_W-1:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        if (n == 64) hang("read");
        rready <= 1'h0;
        rd = rdata;
        resp = rresp;
        @(posedge sys_clk);
    endtask : axiRead

    task automatic pulse(input cause_events_t e);
        hwEvents <= e;
        @(posedge sys_clk);
        hwEvents <= '0;
        @(posedge sys_clk);
    endtask : pulse

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic testReset();
        axiRead(CAUSE_OFFSET);
        check(rd, 32'h0000_0003, "cause after reset");
        check({31'h0, regulatorSleepKeepOn}, 32'h0, "keep-on after reset");
        axiRead(IRQ_MASK_OFFSET);
        check(rd, 32'h0, "mask after reset");
        check({31'h0, irq}, 32'h0, "irq after reset");
        $display("reset test done");
    endtask : testReset

    task automatic testEvents();
        int bitPos [9] = '{2, 3, 4, 6, 7, 9, 29, 1, 0};
        for (int i = 0; i < 9; i++) begin
            axiWrite(CAUSE_OFFSET, '0, 4'hF);
            pulse(cause_events_t'(9'h001 << i));
            repeat (3) @(posedge sys_clk);
            axiRead(CAUSE_OFFSET);
            check(rd, 32'h1 << bitPos[i], "event flag");
        end
        $display("event test done");
    endtask : testEvents

    task automatic testWrites();
        axiWrite(CAUSE_OFFSET, 32'hFFFF_FFFF, 4'hF);
        check({30'h0, resp}, 32'h0, "write response");
        axiRead(CAUSE_OFFSET);
        check(rd, 32'h2000_03DF, "all ones written");
        check({31'h0, regulatorSleepKeepOn}, 32'h1, "keep-on set");
        axiWrite(CAUSE_OFFSET, '0, 4'hF);
        check({31'h0, regulatorSleepKeepOn}, 32'h0, "keep-on cleared");
        axiWrite(CAUSE_OFFSET, 32'hFFFF_FFFF, 4'h2);
        axiRead(CAUSE_OFFSET);
        check(rd, 32'h0000_0300, "one lane written");
        $display("write test done");
    endtask : testWrites

    // a set event landing on the very edge of a clearing write must survive it
    task automatic testHwWins();
        fork
            axiWrite(CAUSE_OFFSET, '0, 4'hF);
            pulse(9'h080);
        join
        axiRead(CAUSE_OFFSET);
        check(rd, 32'h0000_0002, "set beats clear");
        fork
            axiWrite(IRQ_STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF);
            pulse(9'h004);
        join
        axiRead(IRQ_STATUS_OFFSET);
        check(rd, 32'h0000_0010, "set beats status clear");
        $display("collision test done");
    endtask : testHwWins

    task automatic testIrq();
        check({31'h0, irq}, 32'h0, "irq masked off");
        axiWrite(IRQ_MASK_OFFSET, 32'hFFFF_FFFF, 4'hF);
        axiRead(IRQ_MASK_OFFSET);
        check(rd, 32'h2000_02DF, "mask layout");
        axiWrite(IRQ_MASK_OFFSET, 32'h0000_0008, 4'hF);
        check({31'h0, irq}, 32'h0, "irq other bit masked");
        pulse(9'h002);
        check({31'h0, irq}, 32'h1, "irq raised");
        axiWrite(IRQ_STATUS_OFFSET, 32'h0000_0008, 4'hF);
        check({31'h0, irq}, 32'h0, "irq cleared");
        axiRead(IRQ_STATUS_OFFSET);
        check(rd, 32'h0000_0010, "status after clear");
        $display("interrupt test done");
    endtask : testIrq

    task automatic testUnmapped();
        axiWrite(CAUSE_OFFSET, 32'h0000_0002, 4'hF);
        axiWrite(8'h0C, 32'hFFFF_FFFF, 4'hF);
        check({30'h0, resp}, 32'h2, "unmapped write response");
        axiRead(8'h0C);
        check({30'h0, resp}, 32'h2, "unmapped read response");
        check(rd, 32'h0, "unmapped read data");
        axiRead(CAUSE_OFFSET);
        check(rd, 32'h0000_0002, "cause untouched");
        $display("unmapped test done");
    endtask : testUnmapped

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'h1;
        @(posedge sys_clk);
        testReset();
        testEvents();
        testWrites();
        testHwWins();
        testIrq();
        testUnmapped();
        wrapUp();
    end
endmodule : reset_cause_status_tb
